// [pkg/efc_cfg.svh]
// Register indices, field positions, reset values for the eFuse control
`ifndef EFC_CFG_SVH
`define EFC_CFG_SVH

`define EFC_IDX_OVR_LOW   8'h4e
`define EFC_IDX_OVR_HIGH  8'h4f
`define EFC_IDX_PRG_CTRL  8'h51
`define EFC_IDX_RDO_LOW   8'h53
`define EFC_IDX_RDO_HIGH  8'h54

`define EFC_RST_OVR_LOW   16'h0000
`define EFC_RST_OVR_HIGH  16'h0000
`define EFC_RST_PRG_CTRL  16'h0400

`define EFC_BIT_PRG_MODE  15
`define EFC_BIT_BANK      14
`define EFC_BIT_BANK_BLOW 13
`define EFC_BIT_PRG_EN    12
`define EFC_BIT_LOAD      11
`define EFC_BIT_CLEAR_N   10
`define EFC_ADDR_MSB      4
`define EFC_ADDR_LSB      0

`define EFC_OVR_HIGH_MSB  1

`endif

// [pkg/efc_pkg.sv]
// Types shared by the eFuse control block
package efc_pkg;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [9:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } efc_avm_req_s;

   typedef struct packed {
      logic       prog_mode;
      logic       bank_choice;
      logic       blow_bank;
      logic       blow_bit;
      logic       load;
      logic       clear_n;
      logic [4:0] program_address;
   } efc_fuse_cmd_s;

   typedef enum logic [0:0] {
      EFC_BUS_IDLE = 1'b0,
      EFC_BUS_ACK  = 1'b1
   } efc_bus_e;

endpackage

// [hw/efc_fuse_array.sv]
// Two banks of one-time fuses, bank-select fuse and the fuse latches
`timescale 1ns/1ps
module efc_fuse_array #(
   parameter int FUSE_W = 32
) (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire efc_pkg::efc_fuse_cmd_s cmd,
   output logic [FUSE_W-1:0]          latch_q,
   output logic                       bank_fuse_q,
   output logic                       loaded_q
);
   import efc_pkg::*;

   logic [FUSE_W-1:0] bank_mem [0:1];
   logic [FUSE_W-1:0] blow_mask;

   // One-hot decode of the programming address
   always_comb begin
      blow_mask = '0;
      blow_mask[cmd.program_address] = 1'b1;
   end

   // One addressed bit of the chosen bank blows per pulse
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bank_mem[0] <= '0;
         bank_mem[1] <= '0;
      end else if (cmd.prog_mode && cmd.blow_bit) begin
         bank_mem[cmd.bank_choice] <=
            bank_mem[cmd.bank_choice] | blow_mask; // [RQ8]
      end
   end

   // Bank-select fuse blows at once on its pulse
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bank_fuse_q <= 1'b0;
      end else if (cmd.prog_mode && cmd.blow_bank) begin
         bank_fuse_q <= 1'b1; // [RQ7]
      end
   end

   // Latches clear on the low clear level, else load on request
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         latch_q  <= '0;
         loaded_q <= 1'b0;
      end else if (!cmd.clear_n) begin
         latch_q  <= '0; // [RQ10]
         loaded_q <= 1'b0;
      end else if (cmd.load) begin
         latch_q  <= bank_mem[bank_fuse_q]; // [RQ9]
         loaded_q <= 1'b1;
      end
   end

endmodule // efc_fuse_array

// [hw/efc_top.sv]
// eFuse program and read control with Avalon-MM register slave
//
// What this block does
// [RQ1] A writable register holds the low sixteen override bits.
// [RQ2] A second writable register holds the two upper override bits.
// [RQ3] Each override bit is ORed with its fuse latch to give the fuse value.
// [RQ4] Overrides have no effect during reset or right after it.
// [RQ5] A mode bit enters programming mode at 1 and leaves it at 0 (reset).
// [RQ6] A bank bit picks bank zero (reset) or bank one for programming.
// [RQ7] Writing 1 to the bank-fuse control blows the bank-select fuse.
// [RQ8] Writing 1 to program enable blows the addressed fuse.
// [RQ9] Writing 1 to the read control loads the bank chosen by that fuse.
// [RQ10] Driving the active-low clear control to 0 clears all 32 latches.
// [RQ11] Software returns the clear control to 1 after every read cycle.
// [RQ12] Software addresses exactly one fuse bit per programming operation.
// [RQ13] A read-only register shows the low sixteen read-out bits.
// [RQ14] A further read-only register shows the upper two read-out bits.
// [RQ15] Software enters mode, sets bank and address, pulses enable, leaves.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "efc_cfg.svh"
module efc_top #(
   parameter int FUSE_W = 32,
   parameter int OVR_W  = 18
) (
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire efc_pkg::efc_avm_req_s  avm_req,
   output logic [31:0]                 avm_readdata,
   output logic                        avm_waitrequest,
   output logic [OVR_W-1:0]            fuse_value,
   output logic                        prog_mode_active,
   output logic                        readout_valid
);
   import efc_pkg::*;

   localparam int LOW_W  = 16;
   localparam int HIGH_W = OVR_W - LOW_W;

   generate
      if (FUSE_W != 32 || OVR_W <= LOW_W || OVR_W > FUSE_W) begin : g_chk
         $error("efc_top: unsupported FUSE_W or OVR_W");
      end
   endgenerate

   // Byte addresses of the registers
   localparam logic [9:0] ADDR_OVR_LOW  = {`EFC_IDX_OVR_LOW, 2'b00};
   localparam logic [9:0] ADDR_OVR_HIGH = {`EFC_IDX_OVR_HIGH, 2'b00};
   localparam logic [9:0] ADDR_PRG_CTRL = {`EFC_IDX_PRG_CTRL, 2'b00};
   localparam logic [9:0] ADDR_RDO_LOW  = {`EFC_IDX_RDO_LOW, 2'b00};
   localparam logic [9:0] ADDR_RDO_HIGH = {`EFC_IDX_RDO_HIGH, 2'b00};

   efc_bus_e          bus_state_reg;
   efc_bus_e          bus_state_next;
   logic [31:0]       rdata_reg;
   logic [31:0]       rdata_next;
   logic [15:0]       ovr_low_reg;
   logic [15:0]       ovr_high_reg;
   logic [15:0]       ctrl_reg;
   logic [15:0]       ctrl_prev_reg;
   logic              ovr_en_reg;
   logic              wr_fire;
   logic [15:0]       wmask;
   logic [15:0]       wdata16;
   efc_fuse_cmd_s     cmd;
   logic [FUSE_W-1:0] latch_q;
   logic              bank_fuse_q;
   logic              loaded_q;
   logic [OVR_W-1:0]  ovr_bits;
   logic [OVR_W-1:0]  fuse_value_next;
   logic [15:0]       rdo_low;
   logic [15:0]       rdo_high;

   // Bus handshake: one wait cycle, answer on the second cycle
   always_comb begin
      bus_state_next = EFC_BUS_IDLE;
      unique case (bus_state_reg)
         EFC_BUS_IDLE: begin
            if (avm_req.read || avm_req.write) begin
               bus_state_next = EFC_BUS_ACK;
            end
         end
         EFC_BUS_ACK: begin
            bus_state_next = EFC_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_state_reg <= EFC_BUS_IDLE;
      end else begin
         bus_state_reg <= bus_state_next;
      end
   end

   assign avm_waitrequest = (avm_req.read || avm_req.write) &&
                            (bus_state_reg == EFC_BUS_IDLE);
   assign wr_fire = avm_req.write && (bus_state_reg == EFC_BUS_ACK);

   // Byte lanes 0 and 1 carry the sixteen register bits
   always_comb begin
      wmask   = {{8{avm_req.byteenable[1]}}, {8{avm_req.byteenable[0]}}};
      wdata16 = avm_req.writedata[15:0];
   end

   // Override low register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ovr_low_reg <= `EFC_RST_OVR_LOW;
      end else if (wr_fire && avm_req.address == ADDR_OVR_LOW) begin
         ovr_low_reg <= (ovr_low_reg & ~wmask) | (wdata16 & wmask); // [RQ1]
      end
   end

   // Override high register, only the two low bits are stored
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ovr_high_reg <= `EFC_RST_OVR_HIGH;
      end else if (wr_fire && avm_req.address == ADDR_OVR_HIGH) begin
         ovr_high_reg[`EFC_OVR_HIGH_MSB:0] <=
            (ovr_high_reg[`EFC_OVR_HIGH_MSB:0] &
             ~wmask[`EFC_OVR_HIGH_MSB:0]) |
            (wdata16[`EFC_OVR_HIGH_MSB:0] &
             wmask[`EFC_OVR_HIGH_MSB:0]); // [RQ2]
      end
   end

   // Program control register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg <= `EFC_RST_PRG_CTRL; // [RQ5] [RQ6]
      end else if (wr_fire && avm_req.address == ADDR_PRG_CTRL) begin
         ctrl_reg <= (ctrl_reg & ~wmask) | (wdata16 & wmask);
      end
   end

   // Previous control value for write-one edge detection
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_prev_reg <= `EFC_RST_PRG_CTRL;
      end else begin
         ctrl_prev_reg <= ctrl_reg;
      end
   end

   // Commands to the array; blow and load fire on a 0 to 1 change, clear acts while its bit is 0
   always_comb begin
      cmd.prog_mode       = ctrl_reg[`EFC_BIT_PRG_MODE]; // [RQ5]
      cmd.bank_choice     = ctrl_reg[`EFC_BIT_BANK]; // [RQ6]
      cmd.blow_bank       = ctrl_reg[`EFC_BIT_BANK_BLOW] &&
                            !ctrl_prev_reg[`EFC_BIT_BANK_BLOW]; // [RQ7]
      cmd.blow_bit        = ctrl_reg[`EFC_BIT_PRG_EN] &&
                            !ctrl_prev_reg[`EFC_BIT_PRG_EN]; // [RQ8] [RQ12]
      cmd.load            = ctrl_reg[`EFC_BIT_LOAD] &&
                            !ctrl_prev_reg[`EFC_BIT_LOAD]; // [RQ9]
      cmd.clear_n         = ctrl_reg[`EFC_BIT_CLEAR_N]; // [RQ10] [RQ11]
      cmd.program_address =
         ctrl_reg[`EFC_ADDR_MSB:`EFC_ADDR_LSB]; // [RQ12]
   end

   efc_fuse_array #(
      .FUSE_W (FUSE_W)
   ) u_array (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .cmd         (cmd),
      .latch_q     (latch_q),
      .bank_fuse_q (bank_fuse_q),
      .loaded_q    (loaded_q)
   );

   // Overrides held off through reset and the cycle after release
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ovr_en_reg <= 1'b0; // [RQ4]
      end else begin
         ovr_en_reg <= 1'b1;
      end
   end

   always_comb begin
      ovr_bits = {ovr_high_reg[HIGH_W-1:0], ovr_low_reg};
      if (!ovr_en_reg) begin
         ovr_bits = '0; // [RQ4]
      end
      fuse_value_next = latch_q[OVR_W-1:0] | ovr_bits; // [RQ3]
   end

   // Effective fuse value to the rest of the device
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fuse_value <= '0;
      end else begin
         fuse_value <= fuse_value_next; // [RQ3]
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prog_mode_active <= 1'b0;
         readout_valid    <= 1'b0;
      end else begin
         prog_mode_active <= ctrl_reg[`EFC_BIT_PRG_MODE];
         readout_valid    <= loaded_q;
      end
   end

   // Read-out views of the latches
   always_comb begin
      rdo_low  = latch_q[LOW_W-1:0]; // [RQ13]
      rdo_high = '0;
      rdo_high[HIGH_W-1:0] = latch_q[OVR_W-1:LOW_W]; // [RQ14]
   end

   // Read data, prepared in the wait cycle; unmapped reads give zero
   always_comb begin
      rdata_next = rdata_reg;
      if (avm_req.read && bus_state_reg == EFC_BUS_IDLE) begin
         rdata_next = 32'h0000_0000;
         unique case (avm_req.address)
            ADDR_OVR_LOW:  rdata_next[15:0] = ovr_low_reg;
            ADDR_OVR_HIGH: rdata_next[15:0] = ovr_high_reg;
            ADDR_PRG_CTRL: rdata_next[15:0] = ctrl_reg;
            ADDR_RDO_LOW:  rdata_next[15:0] = rdo_low; // [RQ13]
            ADDR_RDO_HIGH: rdata_next[15:0] = rdo_high; // [RQ14]
            default:       rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign avm_readdata = rdata_reg;

endmodule // efc_top

// [dv/efc_top_asserts.sv]
// Port-level checks for the eFuse control block
`timescale 1ns/1ps
module efc_top_asserts #(
   parameter int OVR_W = 18
) (
   input wire logic                  clk,
   input wire logic                  sys_rst,
   input wire efc_pkg::efc_avm_req_s avm_req,
   input wire logic [31:0]           avm_readdata,
   input wire logic                  avm_waitrequest,
   input wire logic [OVR_W-1:0]      fuse_value,
   input wire logic                  prog_mode_active,
   input wire logic                  readout_valid
);
   import efc_pkg::*;
   logic rq;
   assign rq = avm_req.read | avm_req.write;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_wr(a);
      avm_req.write && !avm_waitrequest && avm_req.address == a;
   endsequence
   sequence s_rd(a);
      avm_req.read && !avm_waitrequest && avm_req.address == a;
   endsequence
   sequence s_quiet;
      fuse_value == '0 && !prog_mode_active && !readout_valid;
   endsequence
   property p_wait_first;
      rq && !$past(rq) |-> avm_waitrequest;
   endproperty
   property p_one_wait;
      rq && avm_waitrequest |=> !avm_waitrequest;
   endproperty
   property p_mode;
      s_wr(10'h144) |-> ##2
         prog_mode_active == $past(avm_req.writedata[15], 2);
   endproperty
   property p_ovr_low;
      s_wr(10'h138) |-> ##2 (fuse_value[15:0]
         & $past(avm_req.writedata[15:0], 2))
         == $past(avm_req.writedata[15:0], 2);
   endproperty
   property p_ovr_high;
      s_wr(10'h13c) |-> ##2 (fuse_value[17:16]
         & $past(avm_req.writedata[1:0], 2))
         == $past(avm_req.writedata[1:0], 2);
   endproperty
   property p_reset;
      $fell(sys_rst) |-> s_quiet [*2];
   endproperty
   property p_clear;
      s_wr(10'h144) ##0 !avm_req.writedata[10] |-> ##[1:4] !readout_valid;
   endproperty
   property p_rdo_low;
      s_rd(10'h14c) ##0 !readout_valid |-> avm_readdata == 32'h00000000;
   endproperty
   property p_rdo_high;
      s_rd(10'h150) |-> avm_readdata[31:2] == 30'h00000000;
   endproperty
   property p_unmapped;
      avm_req.read && !avm_waitrequest && !(avm_req.address inside
         {10'h138, 10'h13c, 10'h144, 10'h14c, 10'h150})
         |-> avm_readdata == 32'h00000000;
   endproperty
   a_wait_first: assert property (p_wait_first)
      else $error("request not held off in its first cycle");
   a_one_wait: assert property (p_one_wait)
      else $error("wait state longer than one cycle");
   a_mode: assert property (p_mode)
      else $error("mode flag does not follow control bit");
   a_ovr_low: assert property (p_ovr_low)
      else $error("low override bits missing from fuse value");
   a_ovr_high: assert property (p_ovr_high)
      else $error("high override bits missing from fuse value");
   a_reset: assert property (p_reset)
      else $error("outputs not quiet right after reset");
   a_clear: assert property (p_clear)
      else $error("latches not cleared");
   a_rdo_low: assert property (p_rdo_low)
      else $error("readout nonzero before a load");
   a_rdo_high: assert property (p_rdo_high)
      else $error("high readout wider than two bits");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read returned data");
endmodule // efc_top_asserts

bind efc_top efc_top_asserts #(.OVR_W(OVR_W)) u_chk (.clk, .sys_rst,
   .avm_req, .avm_readdata, .avm_waitrequest, .fuse_value,
   .prog_mode_active, .readout_valid);

// [dv/testbench.sv]
// Self-checking bench for the eFuse control block
`timescale 1ns/1ps
module testbench;
   import efc_pkg::*;
   typedef struct {logic [9:0] a; logic [15:0] d; logic [15:0] e;} efc_row_s;
   logic         clk;
   logic         sys_rst;
   efc_avm_req_s req;
   logic [31:0]  rdata;
   logic         wreq;
   logic [17:0]  fval;
   logic         pma;
   logic         rvld;
   logic [31:0]  q;
   int           error_cnt;
   int           comparisons;
   int           cyc;
   logic [9:0]   rst_a [5] = '{10'h138, 10'h13c, 10'h144, 10'h14c, 10'h150};
   logic [15:0]  rst_e [5] = '{16'h0000, 16'h0000, 16'h0400, 16'h0, 16'h0};
   logic [15:0]  prg [10] = '{16'h8400, 16'h8403, 16'h9403, 16'h8403,
      16'hc407, 16'hd407, 16'hc407, 16'h0400, 16'h1405, 16'h0400};
   efc_row_s     rows [8] = '{'{10'h138, 16'ha5c3, 16'ha5c3},
      '{10'h13c, 16'hffff, 16'h0003}, '{10'h144, 16'h041f, 16'h041f},
      '{10'h14c, 16'h1234, 16'h0000}, '{10'h150, 16'hffff, 16'h0000},
      '{10'h200, 16'hbeef, 16'h0000}, '{10'h138, 16'h0000, 16'h0000},
      '{10'h13c, 16'h0000, 16'h0000}};

   efc_top u_dut (.clk(clk), .sys_rst(sys_rst), .avm_req(req),
      .avm_readdata(rdata), .avm_waitrequest(wreq), .fuse_value(fval),
      .prog_mode_active(pma), .readout_valid(rvld));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [9:0] a,
                      input logic [15:0] d);
      logic w;
      @(posedge clk);
      req.read <= !wr;
      req.write <= wr;
      req.address <= a;
      req.writedata <= {16'h0000, d};
      do begin
         @(posedge clk);
         w = wreq;
         q = rdata;
      end while (w !== 1'b0);
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask

   task automatic settle_and_reset_reads;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, rst_a[i], 16'h0000);
         chk(q, {16'h0000, rst_e[i]});
      end
   endtask

   task automatic tally_and_finish;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   initial begin
      req = '0;
      req.byteenable = 4'h3;
      sys_rst = 1'b1;
      error_cnt = 0;
      comparisons = 0;
      cyc = 0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk(fval, 18'h00000);
      settle_and_reset_reads();
      foreach (rows[i]) begin
         bus(1'b1, rows[i].a, rows[i].d);
         bus(1'b0, rows[i].a, 16'h0000);
         chk(q, {16'h0000, rows[i].e});
      end
      foreach (prg[i]) begin
         bus(1'b1, 10'h144, prg[i]);
         repeat (2) @(posedge clk);
         chk(pma, prg[i][15]);
      end
      bus(1'b1, 10'h144, 16'h0c00);
      repeat (4) @(posedge clk);
      chk(rvld, 1'b1);
      chk(fval, 18'h00008);
      bus(1'b0, 10'h14c, 16'h0000);
      chk(q, 32'h00000008);
      bus(1'b1, 10'h138, 16'h0001);
      bus(1'b1, 10'h13c, 16'h0002);
      repeat (4) @(posedge clk);
      chk(fval, 18'h20009);
      bus(1'b1, 10'h144, 16'h0800);
      repeat (4) @(posedge clk);
      chk(rvld, 1'b0);
      chk(fval, 18'h20001);
      bus(1'b0, 10'h14c, 16'h0000);
      chk(q, 32'h00000000);
      bus(1'b1, 10'h144, 16'h0400);
      bus(1'b1, 10'h144, 16'h8400);
      bus(1'b1, 10'h144, 16'ha400);
      bus(1'b1, 10'h144, 16'h0400);
      bus(1'b1, 10'h144, 16'h0c00);
      repeat (4) @(posedge clk);
      bus(1'b0, 10'h14c, 16'h0000);
      chk(q, 32'h00000080);
      // Blow fuse 16 of bank one and read the upper read-out bits
      bus(1'b1, 10'h144, 16'h0400);
      bus(1'b1, 10'h144, 16'hc410);
      bus(1'b1, 10'h144, 16'hd410);
      bus(1'b1, 10'h144, 16'hc410);
      bus(1'b1, 10'h144, 16'h0400);
      bus(1'b1, 10'h144, 16'h0c00);
      repeat (4) @(posedge clk);
      bus(1'b0, 10'h150, 16'h0000);
      chk(q, 32'h00000001);
      bus(1'b0, 10'h14c, 16'h0000);
      chk(q, 32'h00000080);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      chk(fval, 18'h00000);
      chk(rvld, 1'b0);
      sys_rst <= 1'b0;
      settle_and_reset_reads();
      tally_and_finish();
   end
endmodule // testbench
